/* fmmd_pkg.sv */
package fmmd_pkg;

  localparam int          NUM_SREG   = 32;
  localparam int          POP_MAX    = 16;
  localparam int          EXP_BIAS   = 127;
  localparam int          RM_LSB     = 22;
  localparam int          FLAG_LSB   = 28;
  localparam logic [1:0]  RM_NEAREST = 2'h0;
  localparam logic [1:0]  RM_PLUS    = 2'h1;
  localparam logic [1:0]  RM_MINUS   = 2'h2;
  localparam logic [1:0]  RM_ZERO    = 2'h3;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] QNAN       = 32'h7fc0_0000;
  localparam logic [7:0]  EXP_MAX    = 8'hff;

  typedef enum logic [3:0] {
    OP_MUL_ACC     = 4'h0,
    OP_MUL_SUB     = 4'h1,
    OP_NEG_MUL_ACC = 4'h2,
    OP_NEG_MUL_SUB = 4'h3,
    OP_MULTIPLY    = 4'h4,
    OP_NEG_MULT    = 4'h5,
    OP_NEGATE      = 4'h6,
    OP_MOVE_IMM    = 4'h7,
    OP_MOVE_REG    = 4'h8,
    OP_MOVE_HALF   = 4'h9,
    OP_MOVE_SINGLE = 4'ha,
    OP_MOVE_PAIR   = 4'hb,
    OP_STATUS_RD   = 4'hc,
    OP_STATUS_WR   = 4'hd,
    OP_STACK_POP   = 4'he
  } fmmd_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MUL  = 2'b01,
    ST_ACC  = 2'b11,
    ST_POP  = 2'b10
  } fmmd_state_e;

  typedef struct packed {
    fmmd_op_e    op;
    logic [4:0]  dest;
    logic [4:0]  src_n;
    logic [4:0]  src_m;
    logic        dest_omit;
    logic        dbl;
    logic        half;
    logic        to_core;
    logic        flags_sel;
    logic [3:0]  core_idx;
    logic [3:0]  core_idx_b;
    logic [4:0]  count;
    logic [31:0] imm;
  } fmmd_cmd_s;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [31:0] data;
  } fmmd_core_wr_s;

endpackage

/* fmmd_datapath.sv */
// Contract
// - Accumulate: dest plus product of sources
// - Subtract: dest minus product of sources
// - Immediate constant written to float register
// - Register copy, double and single forms
// - Half read: index 0 low, 1 high
// - Single register to and from core
// - Pair uses register and its successor
// - Pair core indices are independent
// - Half write: index 0 low, 1 high
// - Status register copied to core register
// - Status flags copied to core flags
// - Core register loads status register
// - Multiply stores product in dest, or in src_n when dest_omit is set
// - Negate flips only the sign bit
// - Negated accumulate: minus dest minus product
// - Negated subtract: product minus dest
// - Negated multiply writes product with its sign bit flipped
// - Pop one to sixteen consecutive registers, or one to sixteen register pairs when double
module fmmd_datapath (
  // Clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  // Command and core operands
  input  wire logic                   cmd_valid_i,
  input  wire fmmd_pkg::fmmd_cmd_s    cmd_i,
  input  wire logic [31:0]            core_val_i,
  input  wire logic [31:0]            core_val_b_i,
  // Stack data
  input  wire logic                   pop_valid_i,
  input  wire logic [31:0]            pop_data_i,
  output logic                        pop_req_o,
  // Core writeback
  output fmmd_pkg::fmmd_core_wr_s     core_wr_o,
  output fmmd_pkg::fmmd_core_wr_s     core_wr_b_o,
  output logic                        flags_wr_o,
  output logic [3:0]                  flags_o,
  // Status
  output logic                        busy_o,
  output logic                        done_o,
  output logic [31:0]                 status_o
);

  function automatic logic [31:0] fp_round(input logic s, input int e, input logic [26:0] m,
                                           input logic [1:0] rm);
    logic        inc;
    logic [24:0] r;
    int          ee;
    ee = e;
    if (ee <= 0) return {s, 31'h0};
    case (rm)
      fmmd_pkg::RM_NEAREST: inc = m[2] & (m[3] | m[1] | m[0]);
      fmmd_pkg::RM_PLUS:    inc = ~s & (|m[2:0]);
      fmmd_pkg::RM_MINUS:   inc = s & (|m[2:0]);
      default:              inc = 1'b0;
    endcase
    r = {1'b0, m[26:3]} + {24'h0, inc};
    if (r[24]) ee = ee + 1;
    if (ee >= 255) return {s, fmmd_pkg::EXP_MAX, 23'h0};
    return {s, 8'(ee), r[22:0]};
  endfunction

  function automatic logic [31:0] fp_mul(input logic [31:0] a, input logic [31:0] b,
                                         input logic [1:0] rm);
    logic [47:0] p;
    logic        s;
    int          e;
    s = a[31] ^ b[31];
    if ((a[30:23] == fmmd_pkg::EXP_MAX && a[22:0] != 23'h0) ||
        (b[30:23] == fmmd_pkg::EXP_MAX && b[22:0] != 23'h0)) return fmmd_pkg::QNAN;
    if (a[30:23] == fmmd_pkg::EXP_MAX || b[30:23] == fmmd_pkg::EXP_MAX) begin
      if (a[30:23] == 8'h0 || b[30:23] == 8'h0) return fmmd_pkg::QNAN;
      return {s, fmmd_pkg::EXP_MAX, 23'h0};
    end
    if (a[30:23] == 8'h0 || b[30:23] == 8'h0) return {s, 31'h0};
    p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e = int'(a[30:23]) + int'(b[30:23]) - fmmd_pkg::EXP_BIAS;
    if (p[47]) e = e + 1;
    else p = p << 1;
    return fp_round(s, e, {p[47:22], |p[21:0]}, rm);
  endfunction

  function automatic logic [31:0] fp_add(input logic [31:0] a, input logic [31:0] b,
                                         input logic [1:0] rm);
    logic [31:0] x;
    logic [31:0] y;
    logic [27:0] mx;
    logic [27:0] my;
    logic [7:0]  d;
    int          e;
    if (a[30:23] == fmmd_pkg::EXP_MAX || b[30:23] == fmmd_pkg::EXP_MAX) begin
      if ((a[30:23] == fmmd_pkg::EXP_MAX && a[22:0] != 23'h0) ||
          (b[30:23] == fmmd_pkg::EXP_MAX && b[22:0] != 23'h0) ||
          (a[30:23] == b[30:23] && a[31] != b[31])) return fmmd_pkg::QNAN;
      return (a[30:23] == fmmd_pkg::EXP_MAX) ? a : b;
    end
    if (b[30:23] == 8'h0) return (a[30:23] == 8'h0) ? {a[31] & b[31], 31'h0} : a;
    if (a[30:23] == 8'h0) return b;
    if (a[30:0] < b[30:0]) begin
      x = b;
      y = a;
    end else begin
      x = a;
      y = b;
    end
    d  = x[30:23] - y[30:23];
    mx = {2'b01, x[22:0], 3'h0};
    my = {2'b01, y[22:0], 3'h0};
    if (d > 8'h1a) my = 28'h1;
    else my = (my >> d) | {27'h0, |(my & ~(28'hfffffff << d))};
    e = int'(x[30:23]);
    if (x[31] == y[31]) mx = mx + my;
    else mx = mx - my;
    if (mx == 28'h0) return {rm == fmmd_pkg::RM_MINUS, 31'h0};
    if (mx[27]) begin
      mx = {1'b0, mx[27:2], mx[1] | mx[0]};
      e  = e + 1;
    end
    for (int i = 0; i < 27; i++) begin
      if (!mx[26]) begin
        mx = mx << 1;
        e  = e - 1;
      end
    end
    return fp_round(x[31], e, mx[26:0], rm);
  endfunction

  fmmd_pkg::fmmd_state_e   state_reg;
  fmmd_pkg::fmmd_state_e   state_next;
  fmmd_pkg::fmmd_cmd_s     cmd_reg;
  fmmd_pkg::fmmd_core_wr_s core_wr_reg;
  fmmd_pkg::fmmd_core_wr_s core_wr_b_reg;
  logic [31:0]             rf_reg [fmmd_pkg::NUM_SREG];
  logic [31:0]             status_reg;
  logic [31:0]             prod_reg;
  logic [5:0]              pop_left_reg;
  logic [4:0]              pop_ptr_reg;
  logic                    pop_req_reg;
  logic                    busy_reg;
  logic                    done_reg;
  logic                    flags_wr_reg;
  logic [3:0]              flags_reg;
  logic                    go;
  logic                    pop_ok;
  logic [1:0]              rm;
  logic [4:0]              mul_dst;
  logic [31:0]             prod_c;
  logic [31:0]             acc_c;
  logic [31:0]             neg_d;
  logic [31:0]             neg_p;
  logic                    we0;
  logic                    we1;
  logic [4:0]              wa0;
  logic [4:0]              wa1;
  logic [31:0]             wd0;
  logic [31:0]             wd1;

  assign go      = cmd_valid_i && (state_reg == fmmd_pkg::ST_IDLE);
  assign pop_ok  = (cmd_i.count != 5'h0) && (cmd_i.count <= 5'(fmmd_pkg::POP_MAX));
  assign rm      = status_reg[fmmd_pkg::RM_LSB +: 2];
  assign mul_dst = cmd_reg.dest_omit ? cmd_reg.src_n : cmd_reg.dest;
  assign prod_c  = fp_mul(rf_reg[cmd_reg.src_n], rf_reg[cmd_reg.src_m], rm);
  assign neg_d   = {~rf_reg[cmd_reg.dest][31], rf_reg[cmd_reg.dest][30:0]};
  assign neg_p   = {~prod_reg[31], prod_reg[30:0]};

  always_comb begin
    unique case (cmd_reg.op)
      fmmd_pkg::OP_MUL_ACC:     acc_c = fp_add(rf_reg[cmd_reg.dest], prod_reg, rm);
      fmmd_pkg::OP_MUL_SUB:     acc_c = fp_add(rf_reg[cmd_reg.dest], neg_p, rm);
      fmmd_pkg::OP_NEG_MUL_ACC: acc_c = fp_add(neg_d, neg_p, rm);
      default:                  acc_c = fp_add(neg_d, prod_reg, rm);
    endcase
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      fmmd_pkg::ST_IDLE: begin
        if (go && cmd_i.op <= fmmd_pkg::OP_NEG_MULT) state_next = fmmd_pkg::ST_MUL;
        if (go && cmd_i.op == fmmd_pkg::OP_STACK_POP && pop_ok) state_next = fmmd_pkg::ST_POP;
      end
      fmmd_pkg::ST_MUL: begin
        if (cmd_reg.op >= fmmd_pkg::OP_MULTIPLY) state_next = fmmd_pkg::ST_IDLE;
        else state_next = fmmd_pkg::ST_ACC;
      end
      fmmd_pkg::ST_ACC:  state_next = fmmd_pkg::ST_IDLE;
      fmmd_pkg::ST_POP: begin
        if (pop_valid_i && pop_left_reg == 6'h1) state_next = fmmd_pkg::ST_IDLE;
      end
    endcase
  end

  // Float register write ports
  always_comb begin
    we0 = 1'b0;
    we1 = 1'b0;
    wa0 = 5'h0;
    wa1 = 5'h0;
    wd0 = 32'h0;
    wd1 = 32'h0;
    unique case (state_reg)
      fmmd_pkg::ST_IDLE: begin
        if (go) begin
          case (cmd_i.op)
            fmmd_pkg::OP_MOVE_IMM: begin
              we0 = 1'b1;
              wa0 = cmd_i.dest;
              wd0 = cmd_i.imm;
            end
            fmmd_pkg::OP_MOVE_REG: begin
              we0 = 1'b1;
              if (cmd_i.dbl) begin
                we1 = 1'b1;
                wa0 = {cmd_i.dest[3:0], 1'b0};
                wa1 = {cmd_i.dest[3:0], 1'b1};
                wd0 = rf_reg[{cmd_i.src_m[3:0], 1'b0}];
                wd1 = rf_reg[{cmd_i.src_m[3:0], 1'b1}];
              end else begin
                wa0 = cmd_i.dest;
                wd0 = rf_reg[cmd_i.src_m];
              end
            end
            fmmd_pkg::OP_NEGATE: begin
              we0 = 1'b1;
              wa0 = cmd_i.dest;
              wd0 = {~rf_reg[cmd_i.src_m][31], rf_reg[cmd_i.src_m][30:0]};
            end
            fmmd_pkg::OP_MOVE_HALF: begin
              we0 = ~cmd_i.to_core;
              wa0 = {cmd_i.dest[3:0], cmd_i.half};
              wd0 = core_val_i;
            end
            fmmd_pkg::OP_MOVE_SINGLE: begin
              we0 = ~cmd_i.to_core;
              wa0 = cmd_i.src_n;
              wd0 = core_val_i;
            end
            fmmd_pkg::OP_MOVE_PAIR: begin
              we0 = ~cmd_i.to_core;
              we1 = ~cmd_i.to_core;
              wa0 = cmd_i.src_m;
              wa1 = cmd_i.src_m + 5'h1;
              wd0 = core_val_i;
              wd1 = core_val_b_i;
            end
            default: ;
          endcase
        end
      end
      fmmd_pkg::ST_MUL: begin
        we0 = (cmd_reg.op >= fmmd_pkg::OP_MULTIPLY);
        wa0 = mul_dst;
        wd0 = (cmd_reg.op == fmmd_pkg::OP_NEG_MULT) ? {~prod_c[31], prod_c[30:0]} : prod_c;
      end
      fmmd_pkg::ST_ACC: begin
        we0 = 1'b1;
        wa0 = cmd_reg.dest;
        wd0 = acc_c;
      end
      fmmd_pkg::ST_POP: begin
        we0 = pop_valid_i;
        wa0 = pop_ptr_reg;
        wd0 = pop_data_i;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < fmmd_pkg::NUM_SREG; i++) rf_reg[i] <= 32'h0;
    end else begin
      if (we0) rf_reg[wa0] <= wd0;
      if (we1) rf_reg[wa1] <= wd1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= fmmd_pkg::ST_IDLE;
      cmd_reg   <= '0;
      prod_reg  <= 32'h0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (go) cmd_reg <= cmd_i;
      if (state_reg == fmmd_pkg::ST_MUL) prod_reg <= prod_c;
      busy_reg  <= (state_next != fmmd_pkg::ST_IDLE);
      done_reg  <= (go && state_next == fmmd_pkg::ST_IDLE) ||
                   (state_reg != fmmd_pkg::ST_IDLE && state_next == fmmd_pkg::ST_IDLE);
    end
  end

  // Stack pop sequencing
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pop_left_reg <= 6'h0;
      pop_ptr_reg  <= 5'h0;
      pop_req_reg  <= 1'b0;
    end else begin
      pop_req_reg <= (state_next == fmmd_pkg::ST_POP);
      if (go && cmd_i.op == fmmd_pkg::OP_STACK_POP) begin
        pop_left_reg <= cmd_i.dbl ? {cmd_i.count, 1'b0} : {1'b0, cmd_i.count};
        pop_ptr_reg  <= cmd_i.dbl ? {cmd_i.dest[3:0], 1'b0} : cmd_i.dest;
      end else if (state_reg == fmmd_pkg::ST_POP && pop_valid_i) begin
        pop_left_reg <= pop_left_reg - 6'h1;
        pop_ptr_reg  <= pop_ptr_reg + 5'h1;
      end
    end
  end

  // Core side transfers and status register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_wr_reg   <= '0;
      core_wr_b_reg <= '0;
      flags_wr_reg  <= 1'b0;
      flags_reg     <= 4'h0;
      status_reg    <= fmmd_pkg::STATUS_RST;
    end else begin
      core_wr_reg.en   <= 1'b0;
      core_wr_b_reg.en <= 1'b0;
      flags_wr_reg     <= 1'b0;
      core_wr_reg.idx  <= cmd_i.core_idx;
      core_wr_b_reg.idx <= cmd_i.core_idx_b;
      if (go) begin
        case (cmd_i.op)
          fmmd_pkg::OP_MOVE_HALF: begin
            core_wr_reg.en   <= cmd_i.to_core;
            core_wr_reg.data <= rf_reg[{cmd_i.src_n[3:0], cmd_i.half}];
          end
          fmmd_pkg::OP_MOVE_SINGLE: begin
            core_wr_reg.en   <= cmd_i.to_core;
            core_wr_reg.data <= rf_reg[cmd_i.src_n];
          end
          fmmd_pkg::OP_MOVE_PAIR: begin
            core_wr_reg.en     <= cmd_i.to_core;
            core_wr_b_reg.en   <= cmd_i.to_core;
            core_wr_reg.data   <= rf_reg[cmd_i.src_m];
            core_wr_b_reg.data <= rf_reg[cmd_i.src_m + 5'h1];
          end
          fmmd_pkg::OP_STATUS_RD: begin
            core_wr_reg.en   <= ~cmd_i.flags_sel;
            core_wr_reg.data <= status_reg;
            flags_wr_reg     <= cmd_i.flags_sel;
            flags_reg        <= status_reg[fmmd_pkg::FLAG_LSB +: 4];
          end
          fmmd_pkg::OP_STATUS_WR: status_reg <= core_val_i;
          default: ;
        endcase
      end
    end
  end

  assign pop_req_o   = pop_req_reg;
  assign core_wr_o   = core_wr_reg;
  assign core_wr_b_o = core_wr_b_reg;
  assign flags_wr_o  = flags_wr_reg;
  assign flags_o     = flags_reg;
  assign busy_o      = busy_reg;
  assign done_o      = done_reg;
  assign status_o    = status_reg;

  a_acc_writeback: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == fmmd_pkg::ST_ACC) |=> (rf_reg[$past(cmd_reg.dest)] == $past(acc_c)) && done_o)
    else $error("accumulate result not written");
  a_mul_two_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (go && cmd_i.op <= fmmd_pkg::OP_NEG_MUL_SUB) |=> (state_reg == fmmd_pkg::ST_MUL) ##1
    (state_reg == fmmd_pkg::ST_ACC) ##1 (state_reg == fmmd_pkg::ST_IDLE))
    else $error("accumulate sequence broken");
  a_imm_move: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (go && cmd_i.op == fmmd_pkg::OP_MOVE_IMM) |=> rf_reg[$past(cmd_i.dest)] == $past(cmd_i.imm))
    else $error("immediate not stored");
  a_neg_sign: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (go && cmd_i.op == fmmd_pkg::OP_NEGATE && cmd_i.dest != cmd_i.src_m) |=>
    (rf_reg[$past(cmd_i.dest)] ^ rf_reg[$past(cmd_i.src_m)]) == 32'h8000_0000)
    else $error("negate changed more than sign");
  a_status_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (go && cmd_i.op == fmmd_pkg::OP_STATUS_WR) |=> status_o == $past(core_val_i))
    else $error("status register not loaded");
  a_flags_copy: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    flags_wr_o |-> flags_o == status_reg[fmmd_pkg::FLAG_LSB +: 4] && !core_wr_o.en)
    else $error("flags differ from status");
  a_half_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (go && cmd_i.op == fmmd_pkg::OP_MOVE_HALF && cmd_i.to_core) |=>
    core_wr_o.en && core_wr_o.data == $past(rf_reg[{cmd_i.src_n[3:0], cmd_i.half}]))
    else $error("wrong half sent to core");
  a_pop_bounded: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == fmmd_pkg::ST_POP) |-> pop_req_o && pop_left_reg != 6'h0 &&
    pop_left_reg <= 6'(2 * fmmd_pkg::POP_MAX))
    else $error("pop count out of range");
  a_mul_dest: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == fmmd_pkg::ST_MUL && cmd_reg.op == fmmd_pkg::OP_MULTIPLY) |=>
    rf_reg[$past(mul_dst)] == $past(prod_c) && done_o)
    else $error("product not in destination");

endmodule

/* fmmd_core_model.sv */
module fmmd_core_model (
  // Clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  // Datapath side
  input  wire fmmd_pkg::fmmd_cmd_s     cmd_i,
  input  wire fmmd_pkg::fmmd_core_wr_s core_wr_i,
  input  wire fmmd_pkg::fmmd_core_wr_s core_wr_b_i,
  input  wire logic                    flags_wr_i,
  input  wire logic [3:0]              flags_i,
  input  wire logic                    pop_req_i,
  // Stall control
  input  wire logic                    slow_i,
  // To datapath
  output logic [31:0]                  core_val_o,
  output logic [31:0]                  core_val_b_o,
  output logic                         pop_valid_o,
  output logic [31:0]                  pop_data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] regs [15];
  logic [3:0]  cond_flags;
  logic [31:0] stack_q [$];
  logic        skip;

  // Index 15 has no register and is never handed over
  assign core_val_o   = regs[cmd_i.core_idx];
  assign core_val_b_o = regs[cmd_i.core_idx_b];

  // Core register and flag writeback
  always @(posedge mclk_i) begin
    if (core_wr_i.en === 1'b1) begin
      regs[core_wr_i.idx] <= core_wr_i.data;
    end
    if (core_wr_b_i.en === 1'b1) begin
      regs[core_wr_b_i.idx] <= core_wr_b_i.data;
    end
    if (flags_wr_i === 1'b1) begin
      cond_flags <= flags_i;
    end
  end

  // Stack words, one per cycle or every other cycle when slow
  always @(negedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pop_valid_o <= 1'b0;
      pop_data_o  <= 32'h5a5a_a5a5;
      skip        <= 1'b0;
    end else begin
      skip <= slow_i & ~skip;
      if (pop_req_i === 1'b1 && !(slow_i && !skip) && stack_q.size() > 0) begin
        pop_valid_o <= 1'b1;
        pop_data_o  <= stack_q.pop_front();
      end else begin
        pop_valid_o <= 1'b0;
        pop_data_o  <= ~pop_data_o;
      end
    end
  end
endmodule

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    fmmd_pkg::fmmd_op_e op;
    logic [31:0]        imm;
    logic [31:0]        res;
    int                 lat;
  } fmmd_row_s;

  logic                    mclk_i      = 1'b0;
  logic                    rst_n_i     = 1'b0;
  logic                    cmd_valid_i = 1'b0;
  fmmd_pkg::fmmd_cmd_s     cmd_i       = '0;
  logic                    slow        = 1'b0;
  logic [31:0]             core_val_i;
  logic [31:0]             core_val_b_i;
  logic [31:0]             pop_data_i;
  logic                    pop_valid_i;
  logic                    pop_req_o;
  logic                    flags_wr_o;
  logic                    busy_o;
  logic                    done_o;
  logic [3:0]              flags_o;
  logic [31:0]             status_o;
  fmmd_pkg::fmmd_core_wr_s core_wr_o;
  fmmd_pkg::fmmd_core_wr_s core_wr_b_o;
  fmmd_pkg::fmmd_cmd_s     c;
  int                      n_errors    = 0;
  int                      checks_done = 0;
  int                      lat;
  logic [31:0]             fs [2]      = '{32'ha0c0_0000, 32'h0040_0000};
  logic [31:0]             rr [2]      = '{32'h3f80_0002, 32'h3f80_0003};
  fmmd_row_s               rows [9]    = '{
    '{fmmd_pkg::OP_MUL_ACC,     32'h0, 32'h40e0_0000, 3},
    '{fmmd_pkg::OP_MUL_SUB,     32'h0, 32'hc0a0_0000, 3},
    '{fmmd_pkg::OP_NEG_MUL_ACC, 32'h0, 32'hc0e0_0000, 3},
    '{fmmd_pkg::OP_NEG_MUL_SUB, 32'h0, 32'h40a0_0000, 3},
    '{fmmd_pkg::OP_MULTIPLY,    32'h0, 32'h40c0_0000, 2},
    '{fmmd_pkg::OP_NEG_MULT,    32'h0, 32'hc0c0_0000, 2},
    '{fmmd_pkg::OP_NEGATE,      32'h0, 32'hc040_0000, 1},
    '{fmmd_pkg::OP_MOVE_IMM,    32'h3e80_0000, 32'h3e80_0000, 1},
    '{fmmd_pkg::OP_MOVE_REG,    32'h0, 32'h4040_0000, 1}};

  always #4 mclk_i = ~mclk_i;

  fmmd_datapath u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .core_val_i(core_val_i), .core_val_b_i(core_val_b_i), .pop_valid_i(pop_valid_i),
    .pop_data_i(pop_data_i), .pop_req_o(pop_req_o), .core_wr_o(core_wr_o),
    .core_wr_b_o(core_wr_b_o), .flags_wr_o(flags_wr_o), .flags_o(flags_o),
    .busy_o(busy_o), .done_o(done_o), .status_o(status_o));

  fmmd_core_model u_core (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .core_wr_i(core_wr_o),
    .core_wr_b_i(core_wr_b_o), .flags_wr_i(flags_wr_o), .flags_i(flags_o),
    .pop_req_i(pop_req_o), .slow_i(slow), .core_val_o(core_val_i),
    .core_val_b_o(core_val_b_i), .pop_valid_o(pop_valid_i), .pop_data_o(pop_data_i));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic fmmd_pkg::fmmd_cmd_s mk(input fmmd_pkg::fmmd_op_e op,
                                            input logic [4:0] d, input logic [4:0] m);
    mk = '0;
    mk.op = op;
    mk.dest = d;
    mk.src_n = d;
    mk.src_m = m;
  endfunction

  // Offer one command, wait for done with a bound, count cycles
  task automatic run(input fmmd_pkg::fmmd_cmd_s cc);
    @(negedge mclk_i);
    cmd_i = cc;
    cmd_valid_i = 1'b1;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    lat = 1;
    while (done_o !== 1'b1 && lat < 64) begin
      @(negedge mclk_i);
      lat++;
    end
  endtask

  task automatic set_s(input logic [4:0] idx, input logic [31:0] v);
    u_core.regs[1] = v;
    c = mk(fmmd_pkg::OP_MOVE_SINGLE, idx, idx);
    c.core_idx = 4'h1;
    run(c);
  endtask

  task automatic chk_s(input string what, input logic [4:0] idx, input logic [31:0] exp);
    u_core.regs[5] = 32'h0bad_0bad;
    c = mk(fmmd_pkg::OP_MOVE_SINGLE, idx, idx);
    c.to_core = 1'b1;
    c.core_idx = 4'h5;
    run(c);
    @(negedge mclk_i);
    chk(what, u_core.regs[5], exp);
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    $display("[FAIL] watchdog expected end seen hang");
    complete_run();
  end

  initial begin
    repeat (8) @(negedge mclk_i);
    rst_n_i = 1'b1;
    chk("reset flags", {busy_o, done_o, pop_req_o, flags_wr_o, core_wr_o.en, core_wr_b_o.en}, 0);
    chk("reset status", status_o, 32'h0);
    foreach (rows[i]) begin
      set_s(5'h1, 32'h3f80_0000);
      set_s(5'h2, 32'h4000_0000);
      set_s(5'h3, 32'h4040_0000);
      c = mk(rows[i].op, 5'h1, 5'h3);
      c.src_n = 5'h2;
      c.imm = rows[i].imm;
      run(c);
      chk("latency", 32'(lat), 32'(rows[i].lat));
      chk_s("result", 5'h1, rows[i].res);
    end
    $display("test arithmetic rows done");
    for (int x = 0; x < 2; x++) begin
      u_core.regs[1] = 32'h1000_0000 + x;
      c = mk(fmmd_pkg::OP_MOVE_HALF, 5'h2, 5'h2);
      c.half = x[0];
      c.core_idx = 4'h1;
      run(c);
    end
    chk_s("half low", 5'h4, 32'h1000_0000);
    chk_s("half high", 5'h5, 32'h1000_0001);
    for (int x = 1; x >= 0; x--) begin
      c = mk(fmmd_pkg::OP_MOVE_HALF, 5'h2, 5'h2);
      c.half = x[0];
      c.to_core = 1'b1;
      c.core_idx = 4'h6;
      run(c);
      @(negedge mclk_i);
      chk("half read", u_core.regs[6], 32'h1000_0000 + x);
    end
    c = mk(fmmd_pkg::OP_MOVE_REG, 5'h3, 5'h2);
    c.dbl = 1'b1;
    run(c);
    chk_s("double low", 5'h6, 32'h1000_0000);
    chk_s("double high", 5'h7, 32'h1000_0001);
    $display("test halves and doubles done");
    u_core.regs[2] = 32'haaaa_0002;
    u_core.regs[9] = 32'hbbbb_0009;
    c = mk(fmmd_pkg::OP_MOVE_PAIR, 5'h8, 5'h8);
    c.core_idx = 4'h2;
    c.core_idx_b = 4'h9;
    run(c);
    chk_s("pair first", 5'h8, 32'haaaa_0002);
    chk_s("pair second", 5'h9, 32'hbbbb_0009);
    c = mk(fmmd_pkg::OP_MOVE_PAIR, 5'h8, 5'h8);
    c.to_core = 1'b1;
    c.core_idx = 4'hb;
    c.core_idx_b = 4'h0;
    run(c);
    @(negedge mclk_i);
    chk("pair out a", u_core.regs[11], 32'haaaa_0002);
    chk("pair out b", u_core.regs[0], 32'hbbbb_0009);
    $display("test pair moves done");
    for (int i = 0; i < 2; i++) begin
      u_core.regs[3] = fs[i];
      c = mk(fmmd_pkg::OP_STATUS_WR, 5'h0, 5'h0);
      c.core_idx = 4'h3;
      run(c);
      chk("status write", status_o, fs[i]);
      if (i == 0) begin
        c = mk(fmmd_pkg::OP_STATUS_RD, 5'h0, 5'h0);
        c.core_idx = 4'he;
        run(c);
        c.flags_sel = 1'b1;
        run(c);
        @(negedge mclk_i);
        chk("status read", u_core.regs[14], fs[0]);
        chk("core flags", u_core.cond_flags, 4'ha);
      end
      set_s(5'ha, 32'h3f80_0001);
      c = mk(fmmd_pkg::OP_MULTIPLY, 5'h14, 5'ha);
      c.src_n = 5'ha;
      c.dest_omit = 1'b1;
      run(c);
      chk_s("rounded product", 5'ha, rr[i]);
    end
    $display("test status and rounding done");
    slow = 1'b1;
    u_core.stack_q = '{32'h1111_1111, 32'h2222_2222, 32'h3333_3333, 32'h4444_4444};
    c = mk(fmmd_pkg::OP_STACK_POP, 5'hc, 5'h0);
    c.count = 5'h2;
    run(c);
    c.dest = 5'h7;
    c.dbl = 1'b1;
    c.count = 5'h1;
    run(c);
    slow = 1'b0;
    chk_s("pop s12", 5'hc, 32'h1111_1111);
    chk_s("pop s13", 5'hd, 32'h2222_2222);
    chk_s("pop d7 low", 5'he, 32'h3333_3333);
    chk_s("pop d7 high", 5'hf, 32'h4444_4444);
    foreach (fs[i]) begin
      c = mk(fmmd_pkg::OP_STACK_POP, 5'hc, 5'h0);
      c.count = (i == 0) ? 5'h0 : 5'h11;
      run(c);
      chk("bad pop", {pop_req_o, lat[30:0]}, 32'h1);
    end
    $display("test stack pop done");
    @(negedge mclk_i);
    cmd_i = mk(fmmd_pkg::OP_MULTIPLY, 5'h1, 5'h3);
    cmd_valid_i = 1'b1;
    @(negedge mclk_i);
    cmd_i = mk(fmmd_pkg::OP_MOVE_IMM, 5'h19, 5'h19);
    cmd_i.imm = 32'h4120_0000;
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    chk("busy done", {busy_o, done_o}, 2'h1);
    chk_s("ignored move", 5'h19, 32'h0);
    $display("test busy refusal done");
    rst_n_i = 1'b0;
    #2;
    chk("mid reset status", status_o, 32'h0);
    repeat (8) @(negedge mclk_i);
    rst_n_i = 1'b1;
    chk_s("cleared register", 5'h1, 32'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule
